/* dio_params.svh */
// Constants for the port 2 to 4 digital I/O register block.
// Assumes byte-wide registers at byte addresses on a plain register port.
`ifndef DIO_PARAMS_SVH
`define DIO_PARAMS_SVH

// Widths
`define DIO_PORT_W       8
`define DIO_ADDR_W       8
`define DIO_SYNC_STAGES  2

// Register offsets
`define DIO_P2_SEL_LO_OFS  8'h1B
`define DIO_P2_SEL_HI_OFS  8'h1D
`define DIO_P3_IN_OFS      8'h30
`define DIO_P4_IN_OFS      8'h31
`define DIO_P3_OUT_OFS     8'h32
`define DIO_P3_DIR_OFS     8'h34
`define DIO_P3_SEL_LO_OFS  8'h3A
`define DIO_P3_SEL_HI_OFS  8'h3C

// Reset values
`define DIO_DIR_RST     8'h00
`define DIO_SEL_RST     8'h00
`define DIO_RDATA_IDLE  8'h00

// Direction bit values
`define DIO_DIR_IN   1'b0
`define DIO_DIR_OUT  1'b1

`endif

/* dio_pkg.sv */
// Types shared by the port 2 to 4 digital I/O block.
// Assumes dio_params.svh is on the include path.
`include "dio_params.svh"

package dio_pkg;

  // Per-pin function code, high select bit then low select bit
  typedef enum logic [1:0] {
    DIO_FUNC_GPIO = 2'h0,
    DIO_FUNC_PRI  = 2'h1,
    DIO_FUNC_SEC  = 2'h2,
    DIO_FUNC_TER  = 2'h3
  } dio_func_t;

  // One request on the register port
  typedef struct packed {
    logic [`DIO_ADDR_W-1:0] addr;
    logic [`DIO_PORT_W-1:0] wdata;
    logic                   wr;
    logic                   rd;
  } dio_bus_req_t;

  // Drive of one port's pins
  typedef struct packed {
    logic [`DIO_PORT_W-1:0] level;
    logic [`DIO_PORT_W-1:0] oe;
  } dio_pin_drv_t;

endpackage : dio_pkg

/* dio_sync.sv */
// Two-stage synchroniser for pin levels entering the system clock domain.
// Assumes the inputs are asynchronous to sys_clk_i.
`include "dio_params.svh"

module dio_sync #(
  parameter int unsigned WIDTH = `DIO_PORT_W
) (
  // Clock and reset
  input  wire logic             sys_clk_i,
  input  wire logic             sys_rst_i,
  // Levels
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // First stage feeds only the second stage
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;

endmodule : dio_sync

/* dio_ports_two_to_four.sv */
// Digital I/O register block for ports 2, 3 and 4: select, direction,
// output and input registers with per-pin function routing.
// Assumes a single-master register port on sys_clk_i and asynchronous pins.
`include "dio_params.svh"

module dio_ports_two_to_four
  import dio_pkg::*;
(
  // Clock and reset
  input  wire logic                            sys_clk_i,
  input  wire logic                            sys_rst_i,
  // Register port
  input  wire dio_bus_req_t                    bus_req_i,
  output logic             [`DIO_PORT_W-1:0]   bus_rdata_o,
  // Port 2 function routing
  output dio_func_t        [`DIO_PORT_W-1:0]   p2_func_o,
  // Port 3 pins
  input  wire logic        [`DIO_PORT_W-1:0]   p3_pin_i,
  output logic             [`DIO_PORT_W-1:0]   p3_pin_o,
  output logic             [`DIO_PORT_W-1:0]   p3_pin_oe_o,
  // Port 3 module functions
  output dio_func_t        [`DIO_PORT_W-1:0]   p3_func_o,
  input  wire logic        [`DIO_PORT_W-1:0]   p3_mod_pri_i,
  input  wire logic        [`DIO_PORT_W-1:0]   p3_mod_sec_i,
  input  wire logic        [`DIO_PORT_W-1:0]   p3_mod_ter_i,
  output logic             [`DIO_PORT_W-1:0]   p3_mod_in_o,
  // Port 4 pins
  input  wire logic        [`DIO_PORT_W-1:0]   p4_pin_i,
  output logic             [`DIO_PORT_W-1:0]   p4_mod_in_o
);

  localparam int unsigned W = `DIO_PORT_W;

  // Registers
  logic [W-1:0] p2_sel_lo_q;
  logic [W-1:0] p2_sel_hi_q;
  logic [W-1:0] p3_out_q;
  logic [W-1:0] p3_dir_q;
  logic [W-1:0] p3_sel_lo_q;
  logic [W-1:0] p3_sel_hi_q;
  logic [W-1:0] rdata_q;
  logic [W-1:0] rdata_d;

  // Synchronised pin levels
  logic [W-1:0] p3_in_sync;
  logic [W-1:0] p4_in_sync;

  // Pin drive
  dio_pin_drv_t         p3_drv_d;
  dio_pin_drv_t         p3_drv_q;
  dio_func_t    [W-1:0] p2_func;
  dio_func_t    [W-1:0] p3_func;
  logic         [W-1:0] p3_lvl_sel;
  logic         [W-1:0] p3_oe_sel;

  // Write decode
  logic wr_p2_sel_lo;
  logic wr_p2_sel_hi;
  logic wr_p3_out;
  logic wr_p3_dir;
  logic wr_p3_sel_lo;
  logic wr_p3_sel_hi;

  assign wr_p2_sel_lo = bus_req_i.wr && (bus_req_i.addr == `DIO_P2_SEL_LO_OFS);
  assign wr_p2_sel_hi = bus_req_i.wr && (bus_req_i.addr == `DIO_P2_SEL_HI_OFS);
  assign wr_p3_out    = bus_req_i.wr && (bus_req_i.addr == `DIO_P3_OUT_OFS);
  assign wr_p3_dir    = bus_req_i.wr && (bus_req_i.addr == `DIO_P3_DIR_OFS);
  assign wr_p3_sel_lo = bus_req_i.wr && (bus_req_i.addr == `DIO_P3_SEL_LO_OFS);
  assign wr_p3_sel_hi = bus_req_i.wr && (bus_req_i.addr == `DIO_P3_SEL_HI_OFS);

  // Pin inputs cross into the clock domain before anyone reads them
  dio_sync #(
    .WIDTH (W)
  ) u_p3_sync (
    .sys_clk_i (sys_clk_i),
    .sys_rst_i (sys_rst_i),
    .async_i   (p3_pin_i),
    .sync_o    (p3_in_sync)
  );

  dio_sync #(
    .WIDTH (W)
  ) u_p4_sync (
    .sys_clk_i (sys_clk_i),
    .sys_rst_i (sys_rst_i),
    .async_i   (p4_pin_i),
    .sync_o    (p4_in_sync)
  );

  // Port 2 select registers
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      p2_sel_lo_q <= `DIO_SEL_RST;
    end else if (wr_p2_sel_lo) begin
      p2_sel_lo_q <= bus_req_i.wdata;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      p2_sel_hi_q <= `DIO_SEL_RST;
    end else if (wr_p2_sel_hi) begin
      p2_sel_hi_q <= bus_req_i.wdata;
    end
  end

  // Output value has no reset so software must load it before driving
  always_ff @(posedge sys_clk_i) begin
    if (wr_p3_out) begin
      p3_out_q <= bus_req_i.wdata;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      p3_dir_q <= `DIO_DIR_RST;
    end else if (wr_p3_dir) begin
      p3_dir_q <= bus_req_i.wdata;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      p3_sel_lo_q <= `DIO_SEL_RST;
      p3_sel_hi_q <= `DIO_SEL_RST;
    end else begin
      if (wr_p3_sel_lo) begin
        p3_sel_lo_q <= bus_req_i.wdata;
      end
      if (wr_p3_sel_hi) begin
        p3_sel_hi_q <= bus_req_i.wdata;
      end
    end
  end

  // Per-pin function code and pin drive
  genvar gi;
  generate
    for (gi = 0; gi < W; gi++) begin : g_pin
      assign p2_func[gi] = dio_func_t'({p2_sel_hi_q[gi], p2_sel_lo_q[gi]});
      assign p3_func[gi] = dio_func_t'({p3_sel_hi_q[gi], p3_sel_lo_q[gi]});

      always_comb begin
        unique case (p3_func[gi])
          DIO_FUNC_GPIO: p3_lvl_sel[gi] = p3_out_q[gi];
          DIO_FUNC_PRI:  p3_lvl_sel[gi] = p3_mod_pri_i[gi];
          DIO_FUNC_SEC:  p3_lvl_sel[gi] = p3_mod_sec_i[gi];
          DIO_FUNC_TER:  p3_lvl_sel[gi] = p3_mod_ter_i[gi];
        endcase
      end

      assign p3_oe_sel[gi] = (p3_dir_q[gi] == `DIO_DIR_OUT);
    end
  endgenerate

  // One driver for the whole struct, so level and enable always share one writer
  assign p3_drv_d = '{level: p3_lvl_sel, oe: p3_oe_sel};

  // Pin drive is registered; a pin that is not enabled shows low
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      p3_drv_q <= '0;
    end else begin
      p3_drv_q.oe    <= p3_drv_d.oe;
      p3_drv_q.level <= p3_drv_d.level & p3_drv_d.oe;
    end
  end

  assign p3_pin_o    = p3_drv_q.level;
  assign p3_pin_oe_o = p3_drv_q.oe;
  assign p3_func_o   = p3_func;
  assign p2_func_o   = p2_func;
  assign p3_mod_in_o = p3_in_sync;
  assign p4_mod_in_o = p4_in_sync;

  // Read mux; unmapped addresses read zero
  always_comb begin
    unique case (bus_req_i.addr)
      `DIO_P2_SEL_LO_OFS: rdata_d = p2_sel_lo_q;
      `DIO_P2_SEL_HI_OFS: rdata_d = p2_sel_hi_q;
      `DIO_P3_IN_OFS:     rdata_d = p3_in_sync;
      `DIO_P4_IN_OFS:     rdata_d = p4_in_sync;
      `DIO_P3_OUT_OFS:    rdata_d = p3_out_q;
      `DIO_P3_DIR_OFS:    rdata_d = p3_dir_q;
      `DIO_P3_SEL_LO_OFS: rdata_d = p3_sel_lo_q;
      `DIO_P3_SEL_HI_OFS: rdata_d = p3_sel_hi_q;
      default:            rdata_d = `DIO_RDATA_IDLE;
    endcase
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      rdata_q <= `DIO_RDATA_IDLE;
    end else if (bus_req_i.rd) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= `DIO_RDATA_IDLE;
    end
  end

  assign bus_rdata_o = rdata_q;

  // Checks
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  property p_func_code;
    (p3_func_o[0] == dio_func_t'({p3_sel_hi_q[0], p3_sel_lo_q[0]}))
      && (p2_func_o[W-1] == dio_func_t'({p2_sel_hi_q[W-1], p2_sel_lo_q[W-1]}));
  endproperty
  a_func_code: assert property (p_func_code)
    else $error("function code does not match select bits");

  property p_func_pri;
    (p3_func[1] == DIO_FUNC_PRI) && p3_dir_q[1]
      |=> (p3_pin_o[1] == $past(p3_mod_pri_i[1]));
  endproperty
  a_func_pri: assert property (p_func_pri)
    else $error("primary function not routed to pin");

  property p_func_ter;
    (p3_func[2] == DIO_FUNC_TER) && p3_dir_q[2]
      |=> (p3_pin_o[2] == $past(p3_mod_ter_i[2]));
  endproperty
  a_func_ter: assert property (p_func_ter)
    else $error("tertiary function not routed to pin");

  property p_in_read;
    bus_req_i.rd && (bus_req_i.addr == `DIO_P3_IN_OFS)
      |=> (bus_rdata_o == $past(p3_in_sync));
  endproperty
  a_in_read: assert property (p_in_read)
    else $error("port 3 input read does not show pin level");

  // Only meaningful once both stages have left reset
  property p_pin_sync;
    !$past(sys_rst_i) && !$past(sys_rst_i, `DIO_SYNC_STAGES)
      |-> (p3_in_sync == $past(p3_pin_i, `DIO_SYNC_STAGES));
  endproperty
  a_pin_sync: assert property (p_pin_sync)
    else $error("pin level not seen two cycles later");

  property p_gpio_drive;
    (p3_func[0] == DIO_FUNC_GPIO) && p3_dir_q[0]
      |=> (p3_pin_oe_o[0] && (p3_pin_o[0] == $past(p3_out_q[0])));
  endproperty
  a_gpio_drive: assert property (p_gpio_drive)
    else $error("gpio output does not follow output register");

  property p_dir_in;
    !p3_dir_q[3] |=> (!p3_pin_oe_o[3] && !p3_pin_o[3]);
  endproperty
  a_dir_in: assert property (p_dir_in)
    else $error("input pin is driven");

  property p_dir_write;
    wr_p3_dir |=> (p3_dir_q == $past(bus_req_i.wdata)) ##1
      (p3_pin_oe_o == $past(bus_req_i.wdata, 2));
  endproperty
  a_dir_write: assert property (p_dir_write)
    else $error("direction write not applied to enables");

  property p_out_hold;
    !wr_p3_out |=> $stable(p3_out_q);
  endproperty
  a_out_hold: assert property (p_out_hold)
    else $error("output register changed without a write");

  property p_mod_in;
    (p3_func[4] != DIO_FUNC_GPIO) |-> (p3_mod_in_o[4] == p3_in_sync[4]);
  endproperty
  a_mod_in: assert property (p_mod_in)
    else $error("input path lost under module function");

  property p_rst_clear;
    @(posedge sys_clk_i) disable iff (1'b0)
      $fell(sys_rst_i) |-> ((p3_dir_q == `DIO_DIR_RST)
        && (p3_sel_lo_q == `DIO_SEL_RST) && (p3_sel_hi_q == `DIO_SEL_RST)
        && (p2_sel_hi_q == `DIO_SEL_RST));
  endproperty
  a_rst_clear: assert property (p_rst_clear)
    else $error("configuration not cleared by reset");

  property p_rd_idle;
    !bus_req_i.rd |=> (bus_rdata_o == `DIO_RDATA_IDLE);
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside the answer cycle");

  property p_func_sec;
    (p3_func[5] == DIO_FUNC_SEC) && p3_dir_q[5]
      |=> (p3_pin_o[5] == $past(p3_mod_sec_i[5]));
  endproperty
  a_func_sec: assert property (p_func_sec)
    else $error("secondary function not routed to pin");

  property p_p2_sel_write;
    wr_p2_sel_hi
      |=> (p2_sel_hi_q == $past(bus_req_i.wdata));
  endproperty
  a_p2_sel_write: assert property (p_p2_sel_write)
    else $error("port 2 high select write lost");

  property p_sel_lo_write;
    wr_p3_sel_lo
      |=> (p3_sel_lo_q == $past(bus_req_i.wdata));
  endproperty
  a_sel_lo_write: assert property (p_sel_lo_write)
    else $error("port 3 low select write lost");

  property p_out_write;
    wr_p3_out
      |=> (p3_out_q == $past(bus_req_i.wdata));
  endproperty
  a_out_write: assert property (p_out_write)
    else $error("output value write lost");

  // Input registers ignore writes, so no configuration may move
  property p_ro_write;
    bus_req_i.wr && (bus_req_i.addr == `DIO_P3_IN_OFS)
      |=> $stable(p3_dir_q) && $stable(p3_sel_lo_q) && $stable(p3_sel_hi_q);
  endproperty
  a_ro_write: assert property (p_ro_write)
    else $error("write to input register changed configuration");

  property p_rd_dir;
    bus_req_i.rd && (bus_req_i.addr == `DIO_P3_DIR_OFS)
      |=> (bus_rdata_o == $past(p3_dir_q));
  endproperty
  a_rd_dir: assert property (p_rd_dir)
    else $error("direction read does not show register");

  property p_in_read4;
    bus_req_i.rd && (bus_req_i.addr == `DIO_P4_IN_OFS)
      |=> (bus_rdata_o == $past(p4_in_sync));
  endproperty
  a_in_read4: assert property (p_in_read4)
    else $error("port 4 input read does not show pin level");

endmodule : dio_ports_two_to_four

/* dio_pin_model.sv */
// Far side of the port 2 to 4 block: port 3 and 4 pin wires plus three modules.
// Assumes the bench sets the external levels and the design drives p3 when enabled.
module dio_pin_model #(
  parameter logic [7:0] PRI = 8'h5A,
  parameter logic [7:0] SEC = 8'hC3,
  parameter logic [7:0] TER = 8'h36
) (
  // Design drive
  input  wire logic [7:0] p3_pin_o,
  input  wire logic [7:0] p3_pin_oe_o,
  // External levels
  input  wire logic [7:0] ext3_i,
  input  wire logic [7:0] ext4_i,
  // Wires back to the design
  output logic      [7:0] p3_pin_i,
  output logic      [7:0] p4_pin_i,
  output logic      [7:0] pri_o,
  output logic      [7:0] sec_o,
  output logic      [7:0] ter_o
);
  // A driven pin shows the design's level, otherwise the outside world wins
  assign p3_pin_i = (p3_pin_o & p3_pin_oe_o) | (ext3_i & ~p3_pin_oe_o);
  assign p4_pin_i = ext4_i;
  assign pri_o    = PRI;
  assign sec_o    = SEC;
  assign ter_o    = TER;
endmodule : dio_pin_model

/* dio_ports_two_to_four_tb.sv */
// Self-checking bench for the port 2 to 4 digital I/O block.
// Assumes dio_pkg and dio_pin_model are compiled first.
`include "dio_params.svh"
module dio_ports_two_to_four_tb
  import dio_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] PRI = 8'h5A;
  localparam logic [7:0] SEC = 8'hC3;
  localparam logic [7:0] TER = 8'h36;
  logic            sys_clk_i = 1'b0;
  logic            sys_rst_i = 1'b1;
  dio_bus_req_t    req       = '0;
  logic      [7:0] rdata, p3_pin_i, p3_pin_o, p3_oe, p3_mod_in, p4_pin_i, p4_mod_in;
  logic      [7:0] pri, sec, ter;
  logic      [7:0] ext3      = 8'h00;
  logic      [7:0] ext4      = 8'h00;
  dio_func_t [7:0] p2_func, p3_func;
  int              n_fail    = 0;
  int              samples_checked = 0;
  int              cycles    = 0;

  always #5 sys_clk_i = ~sys_clk_i;

  dio_ports_two_to_four uut (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .bus_req_i(req), .bus_rdata_o(rdata),
    .p2_func_o(p2_func), .p3_pin_i(p3_pin_i), .p3_pin_o(p3_pin_o), .p3_pin_oe_o(p3_oe),
    .p3_func_o(p3_func), .p3_mod_pri_i(pri), .p3_mod_sec_i(sec), .p3_mod_ter_i(ter),
    .p3_mod_in_o(p3_mod_in), .p4_pin_i(p4_pin_i), .p4_mod_in_o(p4_mod_in));

  dio_pin_model #(.PRI(PRI), .SEC(SEC), .TER(TER)) far (
    .p3_pin_o(p3_pin_o), .p3_pin_oe_o(p3_oe), .ext3_i(ext3), .ext4_i(ext4),
    .p3_pin_i(p3_pin_i), .p4_pin_i(p4_pin_i), .pri_o(pri), .sec_o(sec), .ter_o(ter));

  task automatic wrap_up;
    $display("TB: %0d checked, %0d failed", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : wrap_up

  // Generous ceiling: the whole run needs under two hundred cycles
  always @(posedge sys_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_fail++;
      wrap_up();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk_i);
    req.wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe is taken
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk_i);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk_i);
    req.rd <= 1'b0;
    #1;
    chk({8'h00, rdata}, {8'h00, exp});
  endtask : rd

  function automatic logic [15:0] codes(input logic [7:0] hi, input logic [7:0] lo);
    for (int i = 0; i < 8; i++) begin
      codes[2*i +: 2] = {hi[i], lo[i]};
    end
  endfunction : codes

  function automatic logic [7:0] drive(input logic [7:0] hi, input logic [7:0] lo,
                                       input logic [7:0] out, input logic [7:0] dir);
    for (int i = 0; i < 8; i++) begin
      case ({hi[i], lo[i]})
        2'h0: drive[i] = out[i];
        2'h1: drive[i] = PRI[i];
        2'h2: drive[i] = SEC[i];
        default: drive[i] = TER[i];
      endcase
    end
    drive = drive & dir;
  endfunction : drive

  task automatic t_reset;
    rd(`DIO_P3_DIR_OFS, 8'h00);
    rd(`DIO_P3_SEL_LO_OFS, 8'h00);
    rd(`DIO_P3_SEL_HI_OFS, 8'h00);
    rd(`DIO_P2_SEL_HI_OFS, 8'h00);
    chk({8'h00, p3_oe}, 16'h0000);
    chk(p3_func, 16'h0000);
    chk(p2_func, 16'h0000);
    $display("TB: reset test done");
  endtask : t_reset

  task automatic t_input;
    @(posedge sys_clk_i);
    ext3 <= 8'hA5;
    ext4 <= 8'h3C;
    repeat (4) @(posedge sys_clk_i);
    rd(`DIO_P3_IN_OFS, 8'hA5);
    rd(`DIO_P4_IN_OFS, 8'h3C);
    wr(`DIO_P3_IN_OFS, 8'h00);
    rd(`DIO_P3_IN_OFS, 8'hA5);
    rd(8'h50, 8'h00);
    chk({p4_mod_in, p3_mod_in}, 16'h3CA5);
    $display("TB: input test done");
  endtask : t_input

  task automatic t_drive;
    wr(`DIO_P3_OUT_OFS, 8'hC6);
    wr(`DIO_P3_DIR_OFS, 8'h0F);
    rd(`DIO_P3_OUT_OFS, 8'hC6);
    rd(`DIO_P3_DIR_OFS, 8'h0F);
    repeat (4) @(posedge sys_clk_i);
    chk({p3_oe, p3_pin_o}, 16'h0F06);
    rd(`DIO_P3_IN_OFS, 8'hA6);
    $display("TB: drive test done");
  endtask : t_drive

  // Every code on all pins, then a per-bit mix of all four codes
  task automatic t_func;
    logic [7:0] hi_t [5] = '{8'h00, 8'h00, 8'hFF, 8'hFF, 8'hF0};
    logic [7:0] lo_t [5] = '{8'h00, 8'hFF, 8'h00, 8'hFF, 8'hCC};
    for (int k = 0; k < 5; k++) begin
      wr(`DIO_P3_SEL_HI_OFS, hi_t[k]);
      wr(`DIO_P3_SEL_LO_OFS, lo_t[k]);
      wr(`DIO_P2_SEL_HI_OFS, ~hi_t[k]);
      wr(`DIO_P2_SEL_LO_OFS, ~lo_t[k]);
      wr(`DIO_P3_OUT_OFS, 8'h96);
      wr(`DIO_P3_DIR_OFS, 8'hFF);
      repeat (5) @(posedge sys_clk_i);
      chk(p3_func, codes(hi_t[k], lo_t[k]));
      chk(p2_func, codes(~hi_t[k], ~lo_t[k]));
      chk({8'h00, p3_pin_o}, {8'h00, drive(hi_t[k], lo_t[k], 8'h96, 8'hFF)});
      rd(`DIO_P3_IN_OFS, drive(hi_t[k], lo_t[k], 8'h96, 8'hFF));
      rd(`DIO_P3_SEL_HI_OFS, hi_t[k]);
      rd(`DIO_P2_SEL_LO_OFS, ~lo_t[k]);
    end
    $display("TB: function test done");
  endtask : t_func

  // Reset again with every register loaded; the output value is not reset
  task automatic t_midrst;
    @(posedge sys_clk_i);
    sys_rst_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    rd(`DIO_P3_DIR_OFS, 8'h00);
    rd(`DIO_P3_SEL_LO_OFS, 8'h00);
    rd(`DIO_P3_SEL_HI_OFS, 8'h00);
    rd(`DIO_P2_SEL_HI_OFS, 8'h00);
    rd(`DIO_P3_OUT_OFS, 8'h96);
    chk({p3_oe, p3_pin_o}, 16'h0000);
    chk(p3_func, 16'h0000);
    chk(p2_func, 16'h0000);
    rd(`DIO_P3_IN_OFS, 8'hA5);
    $display("TB: mid-run reset test done");
  endtask : t_midrst

  initial begin
    repeat (20) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    t_reset();
    t_input();
    t_drive();
    t_func();
    t_midrst();
    wrap_up();
  end
endmodule : dio_ports_two_to_four_tb
